// ==== hw/hpi_device.sv ====
// Device end of the host port: pin sync, word packing, acknowledge, DMA bus slot
`timescale 1ns/1ps
// Overview of operation
// - Port only ever answers as host's slave
// - Muxed address/data, 8 or 16 bits, async
// - Internal memory access steals one core cycle
// - External memory access never stalls core
// - Detect latch or address-cycle mode automatically
// - Ack polarity caught at reset, read-only
// - Read acks need data, no write busy
// - Write acks need room, no write busy
// - Config bits 7:6 pick ack behaviour
// - Bit 6 set when straps equal
// - Ack mode: ack, strobe drops, ack drops
// - Ready mode: ready low inserts wait states
// - Every address cycle gets ack active
// - Separate selects for memory and I/O space
// - Host sets width and page first
// - Memory selects decoded from target address
// - Pack one to three accesses per word
// - Reads wait for memory on the first beat, writes on the last, other beats acked at once
// - Port increments address itself
// - Fixed priority arbitration, host port level 10
module hpi_device
   import hpi_pkg::*;
(
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RESETN,
   // Host pins
   hpi_if.dev bus,
   // DMA bus arbitration
   input wire logic [NUM_MASTERS-1:0] I_DMA_REQ,
   output logic [NUM_MASTERS-1:0] O_DMA_GRANT,
   // DMA bus memory access
   output logic O_MEM_RD,
   output logic O_MEM_WR,
   output logic [ADDR_W-1:0] O_MEM_ADDR,
   output logic [23:0] O_MEM_WDATA,
   input wire logic [23:0] I_MEM_RDATA,
   input wire logic I_MEM_DONE,
   // Memory selects and core cycle steal
   output logic O_INT_MEM_SEL,
   output logic O_EXT_MEM_SEL,
   output logic O_BOOT_SEL,
   output logic O_IO_SEL,
   output logic O_CORE_STEAL,
   // Status
   output logic O_ADDRESS_CYCLE_MODE,
   output logic [7:0] O_HOST_PORT_CONFIG,
   output logic [7:0] O_TARGET_PAGE_REGISTER
);
   localparam int SW = 23;
   localparam logic [SW-1:0] PIN_IDLE = 23'h6c0000;
   localparam logic [NUM_MASTERS-1:0] HOST_MASK = 12'h400;

   typedef enum logic [1:0] {ST_IDLE, ST_ARB, ST_MEM, ST_HOLD} hpi_dev_state_t;

   // Host accesses per packed word
   function automatic logic [1:0] beats(input logic w16, input logic io);
      beats = io ? (w16 ? 2'h1 : 2'h2) : (w16 ? 2'h2 : 2'h3);
   endfunction

   // Data lane of a packed word for a given access
   function automatic logic [15:0] lane(input logic [23:0] w, input logic [1:0] b, input logic w16);
      if (w16)
         lane = (b == 2'h0) ? w[15:0] : {8'h00, w[23:16]};
      else
         lane = {8'h00, w[8*b +: 8]};
   endfunction

   function automatic logic [23:0] merge(input logic [23:0] w, input logic [1:0] b, input logic w16,
                                         input logic [15:0] d);
      merge = w;
      if (w16 && b == 2'h0)
         merge[15:0] = d;
      else if (w16)
         merge[23:16] = d[7:0];
      else
         merge[8*b +: 8] = d[7:0];
   endfunction

   // Three-stage pin synchroniser, value changes once stages 2 and 3 agree
   logic [SW-1:0] s1, s2, s3, f;
   wire [SW-1:0] pins = {bus.host_write_strobe_n, bus.host_read_strobe_n, bus.host_address_latch_input,
                         bus.memory_space_select_n, bus.io_space_select_n, bus.ack_polarity_select,
                         bus.host_acknowledge, bus.ad};

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         s1 <= PIN_IDLE;
         s2 <= PIN_IDLE;
         s3 <= PIN_IDLE;
         f <= PIN_IDLE;
      end else begin
         s1 <= pins;
         s2 <= s1;
         s3 <= s2;
         f <= (s2 & s3) | (f & (s2 ^ s3));
      end
   end

   wire wr = ~f[22];
   wire rd = ~f[21];
   wire ale = f[20];
   wire cs_mem = ~f[19];
   wire cs_io = ~f[18];
   wire pol_pin = f[17];
   wire ack_pin = f[16];
   wire [15:0] fad = f[15:0];

   hpi_dev_state_t state;
   logic ok, is_data, is_read, is_io, captured, host_req, ack_act;
   logic [1:0] beat;
   logic [3:0] settle;
   logic [15:0] addr16, dout;
   logic [23:0] rbuf;

   wire w16 = O_HOST_PORT_CONFIG[CFG_WIDTH16_BIT];
   wire strobe = (wr | rd) & (cs_mem | cs_io);
   wire acc_cycle = O_ADDRESS_CYCLE_MODE & wr & cs_mem & cs_io;
   wire local_hit = cs_io & (addr16[15:8] == IO_LOCAL_HI);
   wire last_beat = (beat == beats(w16, is_io) - 2'h1);
   wire last_now = (beat == beats(w16, cs_io) - 2'h1);
   wire [23:0] full_addr = {O_TARGET_PAGE_REGISTER, addr16};
   wire int_hit = ~is_io & (O_TARGET_PAGE_REGISTER <= INT_PAGE_LAST);
   wire boot_hit = ~is_io & (O_TARGET_PAGE_REGISTER >= BOOT_PAGE_FIRST);
   wire [7:0] cfg_wr = {fad[7:6], O_HOST_PORT_CONFIG[5:1], fad[0]};

   // Fixed priority: lowest index wins, a granted master keeps the bus
   wire [NUM_MASTERS-1:0] reqs = (I_DMA_REQ & ~HOST_MASK) | (host_req ? HOST_MASK : 12'h000);
   wire [NUM_MASTERS-1:0] lowest = reqs & (~reqs + 12'h001);
   wire [NUM_MASTERS-1:0] next_grant = (|(O_DMA_GRANT & reqs)) ? O_DMA_GRANT : lowest;

   // Ready mode idles active and drops while an access is unfinished
   wire next_ack_act = O_HOST_PORT_CONFIG[CFG_READY_BIT] ? (ok | ~strobe) : (ok & strobe);

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN)
         O_DMA_GRANT <= '0;
      else
         O_DMA_GRANT <= next_grant;
   end

   // Pin outputs; the acknowledge pin stays released until the straps are caught
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         ack_act <= 1'b0;
         bus.dev_ack_out <= 1'b1;
         bus.dev_ack_oe <= 1'b0;
         bus.dev_ad_out <= 16'h0000;
         bus.dev_ad_oe <= 1'b0;
      end else begin
         ack_act <= next_ack_act;
         bus.dev_ack_out <= ~(next_ack_act ^ O_HOST_PORT_CONFIG[CFG_POL_BIT]);
         bus.dev_ack_oe <= captured & ~O_HOST_PORT_CONFIG[CFG_ACKOFF_BIT];
         bus.dev_ad_out <= dout;
         bus.dev_ad_oe <= rd & strobe & ok;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state <= ST_IDLE;
         ok <= 1'b0;
         is_data <= 1'b0;
         is_read <= 1'b0;
         is_io <= 1'b0;
         captured <= 1'b0;
         settle <= 4'h0;
         host_req <= 1'b0;
         beat <= 2'h0;
         addr16 <= 16'h0000;
         dout <= 16'h0000;
         rbuf <= 24'h000000;
         O_MEM_RD <= 1'b0;
         O_MEM_WR <= 1'b0;
         O_MEM_ADDR <= '0;
         O_MEM_WDATA <= 24'h000000;
         O_INT_MEM_SEL <= 1'b0;
         O_EXT_MEM_SEL <= 1'b0;
         O_BOOT_SEL <= 1'b0;
         O_IO_SEL <= 1'b0;
         O_CORE_STEAL <= 1'b0;
         O_ADDRESS_CYCLE_MODE <= 1'b1;
         O_HOST_PORT_CONFIG <= CFG_RESET;
         O_TARGET_PAGE_REGISTER <= PAGE_RESET;
      end else begin
         O_MEM_RD <= 1'b0;
         O_MEM_WR <= 1'b0;
         O_CORE_STEAL <= 1'b0;
         // Straps sampled after the synchroniser has settled past reset
         if (!captured) begin
            settle <= settle + 4'h1;
            if (settle == STRAP_SETTLE) begin
               captured <= 1'b1;
               O_HOST_PORT_CONFIG[CFG_POL_BIT] <= pol_pin;
               O_HOST_PORT_CONFIG[CFG_READY_BIT] <= (pol_pin == ack_pin);
            end
         end
         // Any latch pulse means the host runs in address-latch mode
         if (ale) begin
            O_ADDRESS_CYCLE_MODE <= 1'b0;
            addr16 <= fad;
            beat <= 2'h0;
         end
         case (state)
            ST_IDLE: begin
               if (strobe && captured) begin
                  is_data <= 1'b0;
                  is_read <= rd;
                  is_io <= cs_io;
                  if (acc_cycle) begin
                     addr16 <= fad;
                     beat <= 2'h0;
                     ok <= 1'b1;
                     state <= ST_HOLD;
                  end else if (local_hit) begin
                     if (wr && addr16[7:0] == IO_CFG_ADDR)
                        O_HOST_PORT_CONFIG <= cfg_wr;
                     else if (wr && addr16[7:0] == IO_PAGE_ADDR)
                        O_TARGET_PAGE_REGISTER <= fad[7:0];
                     dout <= (addr16[7:0] == IO_PAGE_ADDR) ? {8'h00, O_TARGET_PAGE_REGISTER}
                                                            : {8'h00, O_HOST_PORT_CONFIG};
                     ok <= 1'b1;
                     state <= ST_HOLD;
                  end else if (rd) begin
                     is_data <= 1'b1;
                     if (beat == 2'h0) begin
                        state <= ST_ARB;
                     end else begin
                        dout <= lane(rbuf, beat, w16);
                        ok <= 1'b1;
                        state <= ST_HOLD;
                     end
                  end else begin
                     is_data <= 1'b1;
                     O_MEM_WDATA <= merge(O_MEM_WDATA, beat, w16, fad);
                     if (last_now) begin
                        state <= ST_ARB;
                     end else begin
                        ok <= 1'b1;
                        state <= ST_HOLD;
                     end
                  end
               end
            end
            ST_ARB: begin
               host_req <= 1'b1;
               if (O_DMA_GRANT[HOST_PRIO]) begin
                  O_MEM_RD <= is_read;
                  O_MEM_WR <= ~is_read;
                  O_MEM_ADDR <= full_addr;
                  O_IO_SEL <= is_io;
                  O_INT_MEM_SEL <= int_hit;
                  O_BOOT_SEL <= boot_hit;
                  O_EXT_MEM_SEL <= ~is_io & ~int_hit & ~boot_hit;
                  O_CORE_STEAL <= int_hit;
                  state <= ST_MEM;
               end
            end
            ST_MEM: begin
               if (I_MEM_DONE) begin
                  host_req <= 1'b0;
                  O_IO_SEL <= 1'b0;
                  O_INT_MEM_SEL <= 1'b0;
                  O_BOOT_SEL <= 1'b0;
                  O_EXT_MEM_SEL <= 1'b0;
                  if (is_read) begin
                     rbuf <= I_MEM_RDATA;
                     dout <= lane(I_MEM_RDATA, beat, w16);
                  end
                  ok <= 1'b1;
                  state <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (!strobe) begin
                  ok <= 1'b0;
                  state <= ST_IDLE;
                  if (is_data && last_beat) begin
                     beat <= 2'h0;
                     addr16 <= addr16 + 16'h0001;
                  end else if (is_data) begin
                     beat <= beat + 2'h1;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule

// ==== hw/hpi_host.sv ====
// Host end of the host port: register-driven strobe sequencer
`timescale 1ns/1ps
module hpi_host
   import hpi_pkg::*;
#(
   parameter logic STRAP_POL = 1'b1,
   parameter logic STRAP_ACK = 1'b1
)
(
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RESETN,
   // Software register port
   input wire logic [1:0] I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [15:0] O_RDATA,
   output logic O_BUSY,
   // Host pins
   hpi_if.host bus
);
   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_WAIT, H_RELEASE, H_GAP} hpi_host_state_t;

   // Three-stage sync of acknowledge and bus
   logic [16:0] s1, s2, s3, f;
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         s1 <= 17'h1ffff;
         s2 <= 17'h1ffff;
         s3 <= 17'h1ffff;
         f <= 17'h1ffff;
      end else begin
         s1 <= {bus.host_acknowledge, bus.ad};
         s2 <= s1;
         s3 <= s2;
         f <= (s2 & s3) | (f & (s2 ^ s3));
      end
   end

   hpi_host_state_t state;
   logic [3:0] cnt, strap_cnt;
   logic [1:0] kind;
   logic io, ready_mode, done;
   logic [15:0] data;

   wire ack_on = (f[16] == STRAP_POL);
   wire is_rd = (kind == K_READ);
   wire is_ale = (kind == K_ALE_ADDR);
   wire start = I_WR && I_ADDR == HREG_CMD && state == H_IDLE;
   wire [15:0] stat = {13'h0000, ack_on, done, O_BUSY};
   wire [15:0] rd_mux = (I_ADDR == HREG_DATA) ? data :
                        (I_ADDR == HREG_STAT) ? stat :
                        (I_ADDR == HREG_CTRL) ? {15'h0000, ready_mode} : {14'h0000, kind};

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_RDATA <= 16'h0000;
         done <= 1'b0;
      end else begin
         O_RDATA <= I_RD ? rd_mux : 16'h0000;
         // A finish in the same cycle as the status read is kept
         if (state == H_GAP && cnt == RECOVER)
            done <= 1'b1;
         else if (I_RD && I_ADDR == HREG_STAT)
            done <= 1'b0;
      end
   end

   // Straps are held on the pins past reset until the device has caught them
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         strap_cnt <= 4'h0;
         bus.ack_polarity_select <= STRAP_POL;
         bus.host_ack_out <= STRAP_ACK;
         bus.host_ack_oe <= 1'b1;
      end else if (strap_cnt != STRAP_HOLD) begin
         strap_cnt <= strap_cnt + 4'h1;
      end else begin
         bus.host_ack_oe <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state <= H_IDLE;
         cnt <= 4'h0;
         kind <= K_READ;
         io <= 1'b0;
         ready_mode <= (STRAP_POL == STRAP_ACK);
         data <= 16'h0000;
         O_BUSY <= 1'b0;
         bus.host_ad_out <= 16'h0000;
         bus.host_ad_oe <= 1'b0;
         bus.host_write_strobe_n <= 1'b1;
         bus.host_read_strobe_n <= 1'b1;
         bus.host_address_latch_input <= 1'b0;
         bus.memory_space_select_n <= 1'b1;
         bus.io_space_select_n <= 1'b1;
      end else begin
         cnt <= cnt + 4'h1;
         if (I_WR && I_ADDR == HREG_DATA)
            data <= I_WDATA;
         if (I_WR && I_ADDR == HREG_CTRL)
            ready_mode <= I_WDATA[0];
         case (state)
            H_IDLE: begin
               if (start && strap_cnt == STRAP_HOLD) begin
                  kind <= I_WDATA[1:0];
                  io <= I_WDATA[CMD_IO_BIT];
                  O_BUSY <= 1'b1;
                  cnt <= 4'h0;
                  state <= H_SETUP;
               end
            end
            H_SETUP: begin
               bus.host_ad_out <= data;
               bus.host_ad_oe <= ~is_rd;
               bus.host_address_latch_input <= is_ale;
               if (!is_ale) begin
                  bus.memory_space_select_n <= ~(~io | kind == K_ACC_ADDR);
                  bus.io_space_select_n <= ~(io | kind == K_ACC_ADDR);
               end
               cnt <= 4'h0;
               state <= is_ale ? H_RELEASE : H_STROBE;
            end
            H_STROBE: begin
               bus.host_read_strobe_n <= ~is_rd;
               bus.host_write_strobe_n <= is_rd;
               cnt <= 4'h0;
               state <= H_WAIT;
            end
            H_WAIT: begin
               if (cnt >= STROBE_MIN && ack_on) begin
                  if (is_rd)
                     data <= f[15:0];
                  bus.host_read_strobe_n <= 1'b1;
                  bus.host_write_strobe_n <= 1'b1;
                  cnt <= 4'h0;
                  state <= H_RELEASE;
               end
            end
            H_RELEASE: begin
               if (is_ale && cnt == ALE_HOLD)
                  bus.host_address_latch_input <= 1'b0;
               if (is_ale ? cnt == (ALE_HOLD + ALE_HOLD) : (ready_mode || !ack_on)) begin
                  bus.host_ad_oe <= 1'b0;
                  bus.memory_space_select_n <= 1'b1;
                  bus.io_space_select_n <= 1'b1;
                  cnt <= 4'h0;
                  state <= H_GAP;
               end
            end
            H_GAP: begin
               if (cnt == RECOVER) begin
                  O_BUSY <= 1'b0;
                  state <= H_IDLE;
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end
endmodule

// ==== hw/hpi_if.sv ====
// Host port pins shared by the device end and the host end
`timescale 1ns/1ps
interface hpi_if;
   logic [15:0] host_ad_out;
   logic host_ad_oe;
   logic [15:0] dev_ad_out;
   logic dev_ad_oe;
   logic [15:0] ad;
   logic host_write_strobe_n;
   logic host_read_strobe_n;
   logic host_address_latch_input;
   logic memory_space_select_n;
   logic io_space_select_n;
   logic ack_polarity_select;
   logic dev_ack_out;
   logic dev_ack_oe;
   logic host_ack_out;
   logic host_ack_oe;
   logic host_acknowledge;
   // Bus and acknowledge pulled high when nobody drives
   assign ad = dev_ad_oe ? dev_ad_out : (host_ad_oe ? host_ad_out : 16'hffff);
   assign host_acknowledge = dev_ack_oe ? dev_ack_out : (host_ack_oe ? host_ack_out : 1'b1);
   modport dev (
      input ad, host_write_strobe_n, host_read_strobe_n, host_address_latch_input,
      input memory_space_select_n, io_space_select_n, ack_polarity_select, host_acknowledge,
      output dev_ad_out, dev_ad_oe, dev_ack_out, dev_ack_oe
   );
   modport host (
      input ad, host_acknowledge,
      output host_ad_out, host_ad_oe, host_write_strobe_n, host_read_strobe_n,
      output host_address_latch_input, memory_space_select_n, io_space_select_n,
      output ack_polarity_select, host_ack_out, host_ack_oe
   );
endinterface

// ==== hw/hpi_pkg.sv ====
// Constants and types shared by both ends of the host port
package hpi_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 24;
   localparam int NUM_MASTERS = 12;
   localparam int HOST_PRIO = 10;
   // Local registers in I/O space, upper address byte zero
   localparam logic [7:0] IO_LOCAL_HI = 8'h00;
   localparam logic [7:0] IO_CFG_ADDR = 8'h00;
   localparam logic [7:0] IO_PAGE_ADDR = 8'h01;
   // host_port_config fields
   localparam int CFG_WIDTH16_BIT = 0;
   localparam int CFG_POL_BIT = 5;
   localparam int CFG_READY_BIT = 6;
   localparam int CFG_ACKOFF_BIT = 7;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   // Page decode of the 24-bit target address
   localparam logic [7:0] INT_PAGE_LAST = 8'h00;
   localparam logic [7:0] BOOT_PAGE_FIRST = 8'hf0;
   // Timing counts in I_CLK_SYS cycles
   localparam logic [3:0] STRAP_SETTLE = 4'h4;
   localparam logic [3:0] STRAP_HOLD = 4'hc;
   localparam logic [3:0] STROBE_MIN = 4'h8;
   localparam logic [3:0] ALE_HOLD = 4'h6;
   localparam logic [3:0] RECOVER = 4'h8;
   // Host controller register offsets
   localparam logic [1:0] HREG_CMD = 2'h0;
   localparam logic [1:0] HREG_DATA = 2'h1;
   localparam logic [1:0] HREG_STAT = 2'h2;
   localparam logic [1:0] HREG_CTRL = 2'h3;
   localparam int CMD_IO_BIT = 2;
   typedef enum logic [1:0] {
      K_READ = 2'h0,
      K_WRITE = 2'h1,
      K_ACC_ADDR = 2'h2,
      K_ALE_ADDR = 2'h3
   } hpi_kind_t;
endpackage

// ==== testbench/host_port_interface_bench.sv ====
// Self-checking bench joining the device end and the host end
`timescale 1ns/1ps
module host_port_interface_bench
   import hpi_pkg::*;
;
   typedef struct {
      hpi_kind_t k;
      logic io;
      logic [15:0] d;
      int n;
      logic [23:0] ea;
      logic [23:0] ed;
      logic [3:0] es;
   } hpi_row_t;
   localparam logic [23:0] NONE = 24'h000000;
   // Selects in order internal, external, boot, io
   hpi_row_t rows [28] = '{
      '{K_ACC_ADDR, 1'b1, 16'h0001, 0, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b1, 16'h0012, 0, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b1, 16'h0012, 0, NONE, NONE, 4'h0},
      '{K_ACC_ADDR, 1'b0, 16'h0340, 0, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b0, 16'h0011, 0, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b0, 16'h0022, 0, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b0, 16'h0033, 1, 24'h120340, 24'h332211, 4'h4},
      '{K_WRITE, 1'b0, 16'h0044, 1, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b0, 16'h0055, 1, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b0, 16'h0066, 2, 24'h120341, 24'h665544, 4'h4},
      '{K_ACC_ADDR, 1'b1, 16'h0001, 2, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b1, 16'h0000, 2, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b1, 16'h0000, 2, NONE, NONE, 4'h0},
      '{K_ACC_ADDR, 1'b0, 16'h0010, 2, NONE, NONE, 4'h0},
      '{K_READ, 1'b0, 16'h0000, 3, 24'h000010, 24'h0000a1, 4'h8},
      '{K_READ, 1'b0, 16'h0000, 3, NONE, 24'h0000b2, 4'h0},
      '{K_READ, 1'b0, 16'h0000, 3, NONE, 24'h0000c3, 4'h0},
      '{K_ACC_ADDR, 1'b1, 16'h0000, 3, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b1, 16'h0001, 3, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b1, 16'h0001, 3, NONE, NONE, 4'h0},
      '{K_ACC_ADDR, 1'b0, 16'h0200, 3, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b0, 16'hbeef, 3, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b0, 16'h00a7, 4, 24'h000200, 24'ha7beef, 4'h8},
      '{K_ACC_ADDR, 1'b1, 16'h0001, 4, NONE, NONE, 4'h0},
      '{K_WRITE, 1'b1, 16'h00f0, 4, NONE, NONE, 4'h0},
      '{K_ACC_ADDR, 1'b0, 16'h0005, 4, NONE, NONE, 4'h0},
      '{K_READ, 1'b0, 16'h0000, 5, 24'hf00005, 24'h00b2a1, 4'h2},
      '{K_READ, 1'b0, 16'h0000, 5, NONE, 24'h0000c3, 4'h0}
   };
   logic clk_sys;
   logic resetn = 1'b0;
   logic [1:0] h_addr = 2'h0;
   logic [15:0] h_wdata = 16'h0000;
   logic h_wr = 1'b0;
   logic h_rd = 1'b0;
   logic [15:0] h_rdata;
   logic h_busy;
   logic [11:0] dma_req = 12'h000;
   logic [11:0] dma_gnt;
   logic mem_rd, mem_wr, mem_done = 1'b0;
   logic [1:0] done_pipe = 2'h0;
   logic [23:0] mem_addr, mem_wdata, last_addr, last_wdata;
   logic [23:0] mem_rdata = 24'hc3b2a1;
   logic sel_int, sel_ext, sel_boot, sel_io, steal, acc_mode, last_steal, last_rd;
   logic [3:0] last_sel;
   logic [11:0] last_gnt;
   logic [7:0] cfg, page;
   logic [15:0] rd, msk;
   int mem_cnt = 0;
   int fails = 0;
   int check_count = 0;

   hpi_if hpi_if_i ();
   hpi_device hpi_device_i (.I_CLK_SYS(clk_sys), .I_RESETN(resetn), .bus(hpi_if_i), .I_DMA_REQ(dma_req),
      .O_DMA_GRANT(dma_gnt), .O_MEM_RD(mem_rd), .O_MEM_WR(mem_wr), .O_MEM_ADDR(mem_addr),
      .O_MEM_WDATA(mem_wdata), .I_MEM_RDATA(mem_rdata), .I_MEM_DONE(mem_done), .O_INT_MEM_SEL(sel_int),
      .O_EXT_MEM_SEL(sel_ext), .O_BOOT_SEL(sel_boot), .O_IO_SEL(sel_io), .O_CORE_STEAL(steal),
      .O_ADDRESS_CYCLE_MODE(acc_mode), .O_HOST_PORT_CONFIG(cfg), .O_TARGET_PAGE_REGISTER(page));
   // Straps select acknowledge mode, active high
   hpi_host #(.STRAP_POL(1'b1), .STRAP_ACK(1'b0)) hpi_host_i (.I_CLK_SYS(clk_sys), .I_RESETN(resetn),
      .I_ADDR(h_addr), .I_WDATA(h_wdata), .I_WR(h_wr), .I_RD(h_rd), .O_RDATA(h_rdata), .O_BUSY(h_busy),
      .bus(hpi_if_i));
   hpi_checker_sva hpi_checker_sva_i (.I_CLK_SYS(clk_sys), .I_RESETN(resetn),
      .host_write_strobe_n(hpi_if_i.host_write_strobe_n), .host_read_strobe_n(hpi_if_i.host_read_strobe_n),
      .ack_polarity_select(hpi_if_i.ack_polarity_select), .host_acknowledge(hpi_if_i.host_acknowledge),
      .dev_ack_oe(hpi_if_i.dev_ack_oe), .dev_ad_oe(hpi_if_i.dev_ad_oe));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Memory answers three cycles after each DMA bus access
   always @(posedge clk_sys) begin
      done_pipe <= {done_pipe[0], mem_rd | mem_wr};
      mem_done <= done_pipe[1];
      if (mem_rd | mem_wr) begin
         mem_cnt <= mem_cnt + 1;
         last_addr <= mem_addr;
         last_wdata <= mem_wdata;
         last_sel <= {sel_int, sel_ext, sel_boot, sel_io};
         last_steal <= steal;
         last_rd <= mem_rd;
         last_gnt <= dma_gnt;
      end
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic do_reset;
      resetn <= 1'b0;
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (20) @(posedge clk_sys);
   endtask

   task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      h_addr <= a;
      h_wdata <= d;
      h_wr <= 1'b1;
      @(posedge clk_sys);
      h_wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      h_addr <= a;
      h_rd <= 1'b1;
      @(posedge clk_sys);
      h_rd <= 1'b0;
      #1 d = h_rdata;
   endtask

   task automatic wait_idle;
      int n;
      @(posedge clk_sys);
      #1;
      for (n = 0; n < 400 && h_busy !== 1'b0; n++) begin
         @(posedge clk_sys);
         #1;
      end
      if (n == 400) begin
         fails++;
         complete_run();
      end
   endtask

   task automatic op(input hpi_kind_t k, input logic io, input logic [15:0] d);
      reg_wr(HREG_DATA, d);
      reg_wr(HREG_CMD, {13'h0000, io, k});
      wait_idle();
      reg_rd(HREG_DATA, rd);
   endtask

   initial begin
      do_reset();
      foreach (rows[i]) begin
         op(rows[i].k, rows[i].io, rows[i].d);
         chk(mem_cnt, rows[i].n);
         // Upper byte is undefined on byte-wide answers
         msk = (rows[i].ed[15:8] != 8'h00) ? 16'hffff : 16'h00ff;
         if (rows[i].k == K_READ) chk(rd & msk, rows[i].ed[15:0]);
         if (rows[i].es != 4'h0) begin
            chk(last_addr, rows[i].ea);
            chk(last_sel, rows[i].es);
            chk(last_steal, rows[i].es[3]);
            chk(last_rd, rows[i].k == K_READ);
            chk(last_gnt, 12'h400);
            if (rows[i].k == K_WRITE) chk(last_wdata, rows[i].ed);
         end
      end
      chk(cfg, 8'h21);
      chk(page, 8'hf0);
      // Higher master holds the bus, a lower one must not win over the port
      op(K_ACC_ADDR, 1'b0, 16'h0006);
      dma_req <= 12'h808;
      reg_wr(HREG_CMD, {13'h0000, 1'b0, K_READ});
      repeat (30) @(posedge clk_sys);
      chk(dma_gnt, 12'h008);
      chk(mem_cnt, 5);
      dma_req <= 12'h800;
      wait_idle();
      chk(mem_cnt, 6);
      chk(last_gnt, 12'h400);
      dma_req <= 12'h000;
      chk(acc_mode, 1'b1);
      op(K_ALE_ADDR, 1'b0, 16'h0007);
      chk(acc_mode, 1'b0);
      do_reset();
      chk(cfg, 8'h20);
      chk(page, 8'h00);
      chk(acc_mode, 1'b1);
      reg_rd(HREG_CTRL, rd);
      chk(rd[0], 1'b0);
      complete_run();
   end
endmodule

// ==== testbench/hpi_checker_sva.sv ====
// Pin-level checks on the link between the two host port ends
`timescale 1ns/1ps
module hpi_checker_sva (
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RESETN,
   // Link pins
   input wire logic host_write_strobe_n,
   input wire logic host_read_strobe_n,
   input wire logic ack_polarity_select,
   input wire logic host_acknowledge,
   input wire logic dev_ack_oe,
   input wire logic dev_ad_oe
);
   // Active level of the answer line follows the strapped polarity
   wire logic strobe_on = !host_write_strobe_n || !host_read_strobe_n;
   wire logic ack_on = dev_ack_oe && (host_acknowledge == ack_polarity_select);

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESETN);

   sequence s_strobe_start;
      $rose(strobe_on);
   endsequence
   sequence s_ack_start;
      $rose(ack_on);
   endsequence

   a_ack_in_strobe: assert property (s_ack_start |-> strobe_on)
      else $error("answer raised with no strobe");
   a_ack_holds: assert property (ack_on && strobe_on |=> ack_on)
      else $error("answer dropped before strobe release");
   a_ack_release: assert property (!strobe_on && ack_on |-> ##[1:8] !ack_on)
      else $error("answer kept after strobe release");
   a_host_waits: assert property (strobe_on && !ack_on |=> strobe_on)
      else $error("strobe released with no answer");
   a_sync_delay: assert property (s_strobe_start |-> !ack_on [*3])
      else $error("answer faster than pin synchroniser");
   a_strobe_answered: assert property (s_strobe_start |-> ##[3:80] ack_on)
      else $error("strobe never answered");
   a_read_drives_ad: assert property ((s_ack_start and (!host_read_strobe_n)) |-> dev_ad_oe)
      else $error("read answered without data on bus");
   a_no_drive_write: assert property (!host_write_strobe_n |-> !dev_ad_oe)
      else $error("device drove bus during write");
   a_ack_after_reset: assert property ($rose(I_RESETN) |-> ##[1:20] dev_ack_oe)
      else $error("answer line not taken after reset");
   a_idle_ack_level: assert property ($rose(dev_ack_oe) |-> !ack_on)
      else $error("answer line starts active");
endmodule
